/* File: core/irq_pkg.sv */
// constants, types and register map of the interrupt and time base block
`default_nettype none
package irq_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL      = 8'h00;
	localparam logic [7:0] OFF_FLAGS     = 8'h04;
	localparam logic [7:0] OFF_SRC_EN    = 8'h08;
	localparam logic [7:0] OFF_TIME_BASE = 8'h0c;
	localparam logic [7:0] OFF_BOUNDS    = 8'h10;
	localparam logic [7:0] OFF_CONV_CFG  = 8'h14;
	localparam logic [7:0] OFF_STATUS    = 8'h18;
	// control register fields
	localparam int CTRL_GLOBAL_EN = 0;
	localparam int CTRL_LOW_EN    = 1;
	localparam int CTRL_INTV_EN   = 2;
	localparam int CTRL_GRP_LSB   = 4;
	// flag and source enable fields
	localparam int FLAG_PWM_PERIOD = 0;
	localparam int FLAG_PWM_DUTY   = 1;
	localparam int FLAG_CONV_DONE  = 4;
	localparam int FLAG_CONV_LIMIT = 5;
	localparam int FLAG_INTERVAL   = 6;
	localparam int FLAG_LOW_SUPPLY = 7;
	localparam int FLAG_GRP_LSB    = 8;
	localparam int FLAG_TMR_P      = 16;
	localparam int FLAG_TMR_A      = 24;
	localparam int GRP_PWM  = 0;
	localparam int GRP_CONV = 1;
	localparam int GRP_TMR  = 2;
	localparam logic [31:0] MASK_PWM  = 32'h0000_000f;
	localparam logic [31:0] MASK_CONV = 32'h0000_0030;
	localparam logic [31:0] MASK_FIX  = 32'h0000_07ff;
	// time base control fields and reset
	localparam int TBR_ON      = 7;
	localparam int TBR_CLK_SEL = 6;
	localparam int TBR_PER_LSB = 4;
	localparam logic [7:0] TBR_RESET = 8'h30;
	localparam logic [7:0] TBR_MASK  = 8'hf0;
	localparam int TB_EXP_BASE = 12;
	localparam int TB_DIV_W    = 15;
	localparam logic [1:0] SYS_DIV_LAST = 2'h3;
	// converter config fields
	localparam int CFG_HIGH_EN = 0;
	localparam int CFG_LOW_EN  = 1;
	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int PC_W = 13;

	typedef enum logic [2:0] {
		VEC_LOW_SUPPLY = 3'b000,
		VEC_GRP_PWM    = 3'b001,
		VEC_GRP_CONV   = 3'b010,
		VEC_GRP_TMR    = 3'b011,
		VEC_INTERVAL   = 3'b100
	} vec_e;

	typedef struct packed {
		logic              aw_got;
		logic              w_got;
		logic [7:0]        awaddr;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} axil_state_s;

	typedef struct packed {
		axil_state_s       bus;
		logic              global_en;
		logic              low_en;
		logic              intv_en;
		logic [2:0]        grp_en;
		logic [31:0]       src_en;
		logic [31:0]       flags;
		logic [7:0]        time_base;
		logic [15:0]       upper_bound;
		logic [15:0]       lower_bound;
		logic              high_cmp_en;
		logic              low_cmp_en;
		logic [1:0]        sys_div;
		logic [14:0]       intv_div;
		logic              intv_s1;
		logic              intv_s2;
		logic              intv_d;
		logic              low_s1;
		logic              low_s2;
		logic              low_d;
		logic              irq_req;
		vec_e              irq_vector;
		logic              stack_push;
		logic [12:0]       stack_push_pc;
		logic              wake;
	} core_state_s;
endpackage : irq_pkg
`default_nettype wire

/* File: core/irq_time_base.sv */
// interrupt request logic, interval generator and register slave
`timescale 1ns/100ps
`default_nettype none
module irq_time_base #(
	parameter int N_TIMERS = 2
) (
	// clock and reset
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	// register bus
	input  wire logic [7:0]             s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output var  logic                   s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output var  logic                   s_axi_wready,
	output var  logic [1:0]             s_axi_bresp,
	output var  logic                   s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [7:0]             s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output var  logic                   s_axi_arready,
	output var  logic [31:0]            s_axi_rdata,
	output var  logic [1:0]             s_axi_rresp,
	output var  logic                   s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// event sources
	input  wire logic                   pwm_period_match_irq,
	input  wire logic [2:0]             pwm_duty_match_irq_n,
	input  wire logic                   conv_done,
	input  wire logic [7:0]             conv_result_high,
	input  wire logic [7:0]             conv_result_low,
	input  wire logic [N_TIMERS-1:0]    timer_p_match,
	input  wire logic [N_TIMERS-1:0]    timer_a_match,
	input  wire logic                   low_supply_detect,
	input  wire logic                   interval_clk_in,
	// cpu sequencer
	input  wire logic                   sleep_mode,
	input  wire logic                   stack_full,
	input  wire logic                   irq_ack,
	input  wire logic [irq_pkg::PC_W-1:0] cpu_pc,
	input  wire logic                   return_from_irq_instr,
	input  wire logic                   return_instr,
	output var  logic                   irq_req,
	output var  irq_pkg::vec_e          irq_vector,
	output var  logic                   stack_push,
	output var  logic [irq_pkg::PC_W-1:0] stack_push_pc,
	output var  logic                   wake
);
	import irq_pkg::*;

	localparam logic [31:0] TMR_ONES = {{(32-N_TIMERS){1'b0}},
		{N_TIMERS{1'b1}}};
	localparam logic [31:0] MASK_TMR = (TMR_ONES << FLAG_TMR_P) |
		(TMR_ONES << FLAG_TMR_A);
	localparam logic [31:0] MASK_ALL = MASK_FIX | MASK_TMR;
	localparam logic [31:0] MASK_SRC = MASK_PWM | MASK_CONV | MASK_TMR;

	core_state_s st;
	core_state_s next_st;

	// merged write data
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	// register read view
	function automatic logic [31:0] reg_read(input logic [7:0] addr,
		input core_state_s s);
		logic [31:0] v;
		v = 32'h0;
		if (addr == OFF_CTRL) begin
			v[CTRL_GLOBAL_EN] = s.global_en;
			v[CTRL_LOW_EN] = s.low_en;
			v[CTRL_INTV_EN] = s.intv_en;
			v[CTRL_GRP_LSB +: 3] = s.grp_en;
		end else if (addr == OFF_FLAGS) begin
			v = s.flags;
		end else if (addr == OFF_SRC_EN) begin
			v = s.src_en;
		end else if (addr == OFF_TIME_BASE) begin
			v[7:0] = s.time_base & TBR_MASK;
		end else if (addr == OFF_BOUNDS) begin
			v = {s.lower_bound, s.upper_bound};
		end else if (addr == OFF_CONV_CFG) begin
			v[CFG_HIGH_EN] = s.high_cmp_en;
			v[CFG_LOW_EN] = s.low_cmp_en;
		end else if (addr == OFF_STATUS) begin
			v[2:0] = s.irq_vector;
			v[3] = s.irq_req;
		end
		return v;
	endfunction : reg_read

	function automatic logic mapped(input logic [7:0] addr);
		logic ok;
		ok = 1'b0;
		if (addr == OFF_CTRL || addr == OFF_FLAGS || addr == OFF_SRC_EN) begin
			ok = 1'b1;
		end else if (addr == OFF_TIME_BASE || addr == OFF_BOUNDS) begin
			ok = 1'b1;
		end else if (addr == OFF_CONV_CFG || addr == OFF_STATUS) begin
			ok = 1'b1;
		end
		return ok;
	endfunction : mapped

	logic        do_wr;
	logic [31:0] wv;
	logic        intv_tick;
	logic        intv_ovf;
	logic [14:0] ovf_mask;
	logic [15:0] result;
	logic        limit_hit;
	logic [31:0] hw_set;
	logic [31:0] rise;
	logic [4:0]  pend;
	logic        service;

	always_comb begin
		next_st = st;
		next_st.stack_push = 1'b0;
		next_st.wake = 1'b0;
		// synchronisers for pins
		next_st.intv_s1 = interval_clk_in;
		next_st.intv_s2 = st.intv_s1;
		next_st.intv_d = st.intv_s2;
		next_st.low_s1 = low_supply_detect;
		next_st.low_s2 = st.low_s1;
		next_st.low_d = st.low_s2;

		// bus write channels
		if (s_axi_awvalid && st.bus.awready) begin
			next_st.bus.aw_got = 1'b1;
			next_st.bus.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st.bus.wready) begin
			next_st.bus.w_got = 1'b1;
			next_st.bus.wdata = s_axi_wdata;
			next_st.bus.wstrb = s_axi_wstrb;
		end
		if (st.bus.bvalid && s_axi_bready) begin
			next_st.bus.bvalid = 1'b0;
		end
		do_wr = st.bus.aw_got && st.bus.w_got && !st.bus.bvalid;
		wv = merge(reg_read(st.bus.awaddr, st), st.bus.wdata,
			st.bus.wstrb);
		if (do_wr) begin
			next_st.bus.aw_got = 1'b0;
			next_st.bus.w_got = 1'b0;
			next_st.bus.bvalid = 1'b1;
			next_st.bus.bresp = mapped(st.bus.awaddr) ? RESP_OKAY
				: RESP_SLVERR;
			if (st.bus.awaddr == OFF_CTRL) begin
				next_st.global_en = wv[CTRL_GLOBAL_EN];
				next_st.low_en = wv[CTRL_LOW_EN];
				next_st.intv_en = wv[CTRL_INTV_EN];
				next_st.grp_en = wv[CTRL_GRP_LSB +: 3];
			end else if (st.bus.awaddr == OFF_FLAGS) begin
				next_st.flags = wv & MASK_ALL;
			end else if (st.bus.awaddr == OFF_SRC_EN) begin
				next_st.src_en = wv & MASK_SRC;
			end else if (st.bus.awaddr == OFF_TIME_BASE) begin
				next_st.time_base = wv[7:0] & TBR_MASK;
			end else if (st.bus.awaddr == OFF_BOUNDS) begin
				next_st.upper_bound = wv[15:0];
				next_st.lower_bound = wv[31:16];
			end else if (st.bus.awaddr == OFF_CONV_CFG) begin
				next_st.high_cmp_en = wv[CFG_HIGH_EN];
				next_st.low_cmp_en = wv[CFG_LOW_EN];
			end
		end

		// bus read channel
		if (s_axi_arvalid && st.bus.arready) begin
			next_st.bus.rvalid = 1'b1;
			next_st.bus.rdata = reg_read(s_axi_araddr, st);
			next_st.bus.rresp = mapped(s_axi_araddr) ? RESP_OKAY
				: RESP_SLVERR;
		end
		if (st.bus.rvalid && s_axi_rready) begin
			next_st.bus.rvalid = 1'b0;
		end
		next_st.bus.awready = !next_st.bus.aw_got && !next_st.bus.bvalid;
		next_st.bus.wready = !next_st.bus.w_got && !next_st.bus.bvalid;
		next_st.bus.arready = !next_st.bus.rvalid;

		// interval generator
		next_st.sys_div = st.sys_div + 2'h1;
		if (st.time_base[TBR_CLK_SEL]) begin
			intv_tick = (st.sys_div == SYS_DIV_LAST);
		end else begin
			intv_tick = st.intv_s2 && !st.intv_d;
		end
		ovf_mask = 15'((32'h1 << (TB_EXP_BASE +
			int'(st.time_base[TBR_PER_LSB +: 2]))) - 32'h1);
		intv_ovf = 1'b0;
		if (!st.time_base[TBR_ON]) begin
			next_st.intv_div = '0;
		end else if (intv_tick) begin
			intv_ovf = ((st.intv_div & ovf_mask) == ovf_mask);
			next_st.intv_div = intv_ovf ? 15'h0
				: st.intv_div + 15'h1;
		end

		// converter limit compare
		result = {conv_result_high, conv_result_low};
		limit_hit = (st.high_cmp_en && result > st.upper_bound) ||
			(st.low_cmp_en && result < st.lower_bound);

		// hardware flag sets
		hw_set = 32'h0;
		hw_set[FLAG_PWM_PERIOD] = pwm_period_match_irq;
		hw_set[FLAG_PWM_DUTY +: 3] = pwm_duty_match_irq_n;
		hw_set[FLAG_CONV_DONE] = conv_done;
		hw_set[FLAG_CONV_LIMIT] = conv_done && limit_hit;
		hw_set[FLAG_INTERVAL] = intv_ovf;
		hw_set[FLAG_LOW_SUPPLY] = st.low_s2 && !st.low_d;
		hw_set = hw_set | ((32'(timer_p_match) << FLAG_TMR_P) |
			(32'(timer_a_match) << FLAG_TMR_A));

		// pending requests, gated by global enable and stack room
		pend = 5'h0;
		pend[VEC_LOW_SUPPLY] = st.flags[FLAG_LOW_SUPPLY] && st.low_en;
		pend[VEC_GRP_PWM] = st.flags[FLAG_GRP_LSB + GRP_PWM] &&
			st.grp_en[GRP_PWM] &&
			|(st.flags & st.src_en & MASK_PWM);
		pend[VEC_GRP_CONV] = st.flags[FLAG_GRP_LSB + GRP_CONV] &&
			st.grp_en[GRP_CONV] &&
			|(st.flags & st.src_en & MASK_CONV);
		pend[VEC_GRP_TMR] = st.flags[FLAG_GRP_LSB + GRP_TMR] &&
			st.grp_en[GRP_TMR] &&
			|(st.flags & st.src_en & MASK_TMR);
		pend[VEC_INTERVAL] = st.flags[FLAG_INTERVAL] && st.intv_en;
		if (!st.global_en || stack_full) begin
			pend = 5'h0;
		end

		// service of the presented vector
		service = irq_ack && st.irq_req;
		if (service) begin
			next_st.global_en = 1'b0;
			next_st.stack_push = 1'b1;
			next_st.stack_push_pc = cpu_pc;
			case (st.irq_vector)
				VEC_LOW_SUPPLY: begin
					next_st.flags[FLAG_LOW_SUPPLY] = 1'b0;
				end
				VEC_GRP_PWM: begin
					next_st.flags[FLAG_GRP_LSB + GRP_PWM] = 1'b0;
				end
				VEC_GRP_CONV: begin
					next_st.flags[FLAG_GRP_LSB + GRP_CONV] = 1'b0;
				end
				VEC_GRP_TMR: begin
					next_st.flags[FLAG_GRP_LSB + GRP_TMR] = 1'b0;
				end
				VEC_INTERVAL: begin
					next_st.flags[FLAG_INTERVAL] = 1'b0;
				end
				default: begin
				end
			endcase
		end
		// irq return re-enables; plain return leaves it cleared
		if (return_from_irq_instr && !return_instr) begin
			next_st.global_en = 1'b1;
		end

		// sets win over clears; flags otherwise hold
		next_st.flags = next_st.flags | hw_set;
		rise = next_st.flags & ~st.flags;
		if (|(rise & MASK_PWM)) begin
			next_st.flags[FLAG_GRP_LSB + GRP_PWM] = 1'b1;
		end
		if (|(rise & MASK_CONV)) begin
			next_st.flags[FLAG_GRP_LSB + GRP_CONV] = 1'b1;
		end
		if (|(rise & MASK_TMR)) begin
			next_st.flags[FLAG_GRP_LSB + GRP_TMR] = 1'b1;
		end
		next_st.wake = sleep_mode && |(next_st.flags & ~st.flags);

		// one request at a time, lowest vector first
		next_st.irq_req = (|pend) && !service;
		if (pend[VEC_LOW_SUPPLY]) begin
			next_st.irq_vector = VEC_LOW_SUPPLY;
		end else if (pend[VEC_GRP_PWM]) begin
			next_st.irq_vector = VEC_GRP_PWM;
		end else if (pend[VEC_GRP_CONV]) begin
			next_st.irq_vector = VEC_GRP_CONV;
		end else if (pend[VEC_GRP_TMR]) begin
			next_st.irq_vector = VEC_GRP_TMR;
		end else if (pend[VEC_INTERVAL]) begin
			next_st.irq_vector = VEC_INTERVAL;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
			st.time_base <= TBR_RESET;
			st.irq_vector <= VEC_LOW_SUPPLY;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from state
	assign s_axi_awready = st.bus.awready;
	assign s_axi_wready  = st.bus.wready;
	assign s_axi_bvalid  = st.bus.bvalid;
	assign s_axi_bresp   = st.bus.bresp;
	assign s_axi_arready = st.bus.arready;
	assign s_axi_rvalid  = st.bus.rvalid;
	assign s_axi_rdata   = st.bus.rdata;
	assign s_axi_rresp   = st.bus.rresp;
	assign irq_req       = st.irq_req;
	assign irq_vector    = st.irq_vector;
	assign stack_push    = st.stack_push;
	assign stack_push_pc = st.stack_push_pc;
	assign wake          = st.wake;
endmodule : irq_time_base
`default_nettype wire

/* File: dv/cpu_seq_model.sv */
// behavioural model of the cpu sequencer and return stack
`timescale 1ns/100ps
`default_nettype none
module cpu_seq_model
	import irq_pkg::*;
#(
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	// bench controls
	input  wire logic                     ack_on,
	input  wire logic                     return_from_irq_instr_on,
	input  wire logic                     full_on,
	output var  int                       n_push,
	// interrupt side
	input  wire logic                     irq_req,
	input  wire logic                     stack_push,
	input  wire logic [irq_pkg::PC_W-1:0] stack_push_pc,
	output var  logic                     irq_ack,
	output var  logic                     stack_full,
	output var  logic [irq_pkg::PC_W-1:0] cpu_pc,
	output var  logic                     return_from_irq_instr,
	output var  logic                     return_instr
);
	logic [PC_W-1:0] ret_stack [$];
	int              hold;

	assign stack_full = full_on || (ret_stack.size() >= DEPTH);

	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_ack <= 1'b0;
			cpu_pc <= '0;
			hold <= 0;
			n_push <= 0;
			return_from_irq_instr <= 1'b0;
			return_instr <= 1'b0;
			ret_stack.delete();
		end else begin
			// no nested calls inside a service routine
			irq_ack <= ack_on && irq_req && !irq_ack && hold == 0;
			return_from_irq_instr <= return_from_irq_instr_on && !stack_push &&
				hold == 1;
			return_instr <= !return_from_irq_instr_on && !stack_push &&
				hold == 1;
			if (stack_push) begin
				cpu_pc <= cpu_pc + 1'b1;
				ret_stack.push_back(stack_push_pc);
				n_push <= n_push + 1;
				hold <= 5;
			end else if (hold == 1) begin
				cpu_pc <= ret_stack.pop_back();
				hold <= 0;
			end else begin
				cpu_pc <= cpu_pc + 1'b1;
				if (hold > 1) begin
					hold <= hold - 1;
				end
			end
		end
	end
endmodule : cpu_seq_model
`default_nettype wire

/* File: dv/irq_time_base_chk.sv */
// port-level checks for the interrupt and time base block
`timescale 1ns/100ps
`default_nettype none
module irq_time_base_chk
	import irq_pkg::*;
(
	// clock and reset
	input wire logic                     aclk,
	input wire logic                     aresetn,
	// register bus
	input wire logic                     s_axi_awvalid,
	input wire logic                     s_axi_awready,
	input wire logic                     s_axi_wvalid,
	input wire logic                     s_axi_wready,
	input wire logic [1:0]               s_axi_bresp,
	input wire logic                     s_axi_bvalid,
	input wire logic                     s_axi_bready,
	input wire logic                     s_axi_arvalid,
	input wire logic                     s_axi_arready,
	input wire logic [31:0]              s_axi_rdata,
	input wire logic [1:0]               s_axi_rresp,
	input wire logic                     s_axi_rvalid,
	input wire logic                     s_axi_rready,
	// cpu side
	input wire logic                     sleep_mode,
	input wire logic                     stack_full,
	input wire logic                     irq_ack,
	input wire logic [irq_pkg::PC_W-1:0] cpu_pc,
	input wire logic                     irq_req,
	input wire irq_pkg::vec_e            irq_vector,
	input wire logic                     stack_push,
	input wire logic [irq_pkg::PC_W-1:0] stack_push_pc,
	input wire logic                     wake
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	push_after_ack_a: assert property (irq_ack && irq_req
		|=> stack_push && stack_push_pc == $past(cpu_pc))
		else $error("acked pc not pushed");
	push_cause_a: assert property (stack_push
		|-> $past(irq_ack && irq_req)) else $error("push without ack");
	push_pulse_a: assert property (stack_push
		|=> !stack_push) else $error("push longer than one cycle");
	req_drop_a: assert property (irq_ack && irq_req
		|=> !irq_req) else $error("request stays after ack");
	full_block_a: assert property (stack_full
		|=> !irq_req) else $error("request while stack full");
	wake_sleep_a: assert property (wake
		|-> $past(sleep_mode)) else $error("wake while awake");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read answer late");
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");

	cover property (irq_ack && irq_req);
	cover property (wake);
	cover property (irq_req && irq_vector == VEC_LOW_SUPPLY);
	cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : irq_time_base_chk

bind irq_time_base irq_time_base_chk i_irq_time_base_chk (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .sleep_mode, .stack_full, .irq_ack,
	.cpu_pc, .irq_req, .irq_vector, .stack_push, .stack_push_pc, .wake
);
`default_nettype wire

/* File: dv/peripheral_interrupt_and_time_base_tb.sv */
// self-checking bench for the interrupt and time base block
`timescale 1ns/100ps
`default_nettype none
module peripheral_interrupt_and_time_base_tb;
	import irq_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, d;
	logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
	logic arvalid = 0, arready, rvalid, rready = 0;
	logic [1:0] bresp, rresp, r;
	logic [9:0] ev = '0;
	logic [15:0] res = '0;
	logic ic = 0, sleep = 0, ack_on = 1, return_from_irq_instr_on = 0, full_on = 0;
	logic irq_ack, stack_full, rfi, rti, irq_req, stack_push, wake;
	logic [PC_W-1:0] cpu_pc, push_pc;
	vec_e vec;
	int n_push, n_wake = 0, num_errors = 0, n_checks = 0, i;
	logic [15:0] cres [3] = '{16'h0200, 16'h0080, 16'h0008};
	logic [31:0] cexp [3] = '{32'h230, 32'h210, 32'h230};

	always #2 aclk = ~aclk;
	always @(posedge aclk) if (wake === 1'b1) n_wake <= n_wake + 1;

	irq_time_base i_irq_time_base (
		.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .pwm_period_match_irq(ev[0]),
		.pwm_duty_match_irq_n(ev[3:1]), .conv_done(ev[4]),
		.conv_result_high(res[15:8]), .conv_result_low(res[7:0]),
		.timer_p_match(ev[7:6]), .timer_a_match(ev[9:8]),
		.low_supply_detect(ev[5]), .interval_clk_in(ic), .sleep_mode(sleep),
		.stack_full, .irq_ack, .cpu_pc, .return_from_irq_instr(rfi),
		.return_instr(rti), .irq_req, .irq_vector(vec), .stack_push,
		.stack_push_pc(push_pc), .wake
	);

	cpu_seq_model i_cpu_seq_model (
		.aclk, .aresetn, .ack_on, .return_from_irq_instr_on, .full_on, .n_push, .irq_req,
		.stack_push, .stack_push_pc(push_pc), .irq_ack, .stack_full,
		.cpu_pc, .return_from_irq_instr(rfi), .return_instr(rti)
	);

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		// response held one cycle before it is taken
		bready <= 1'b1;
		@(posedge aclk);
		r = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		// data held one cycle before it is taken
		rready <= 1'b1;
		@(posedge aclk);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask : rd

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(d, e);
	endtask : rc

	task automatic fire(input logic [9:0] m);
		ev <= m;
		repeat (4) @(posedge aclk);
		ev <= '0;
		repeat (12) @(posedge aclk);
	endtask : fire

	task automatic tick(input int n);
		repeat (n) begin
			ic <= 1'b1;
			repeat (2) @(posedge aclk);
			ic <= 1'b0;
			repeat (2) @(posedge aclk);
		end
	endtask : tick

	task automatic summarize;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : summarize

	initial begin
		repeat (80000) @(posedge aclk);
		num_errors++;
		summarize();
	end

	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rc(OFF_TIME_BASE, 32'h30);
		rc(OFF_CTRL, 32'h0);
		rd(8'h1c);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		wr(8'h1c, 32'h0);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		wr(OFF_TIME_BASE, 32'hff);
		rc(OFF_TIME_BASE, 32'hf0);
		wr(OFF_TIME_BASE, 32'h0);
		// pwm flags with global enable off, then one serviced with it on
		wr(OFF_SRC_EN, 32'hffff_ffff);
		for (i = 0; i < 4; i++) begin
			fire(10'h1 << i);
			rc(OFF_FLAGS, ((32'h2 << i) - 1) | 32'h100);
		end
		wr(OFF_FLAGS, 32'h0);
		wr(OFF_CTRL, 32'h11);
		fire(10'h001);
		rc(OFF_FLAGS, 32'h1);
		rc(OFF_CTRL, 32'h10);
		// converter limits
		wr(OFF_BOUNDS, 32'h0010_0100);
		wr(OFF_CONV_CFG, 32'h3);
		for (i = 0; i < 3; i++) begin
			wr(OFF_FLAGS, 32'h0);
			res <= cres[i];
			fire(10'h010);
			rc(OFF_FLAGS, cexp[i]);
		end
		return_from_irq_instr_on <= 1'b1;
		wr(OFF_CTRL, 32'h21);
		repeat (20) @(posedge aclk);
		rc(OFF_FLAGS, 32'h30);
		rc(OFF_CTRL, 32'h21);
		// timer matches
		wr(OFF_FLAGS, 32'h0);
		wr(OFF_CTRL, 32'h41);
		fire(10'h080);
		rc(OFF_FLAGS, 32'h0002_0000);
		fire(10'h100);
		rc(OFF_FLAGS, 32'h0102_0000);
		chk(32'(n_push), 32'd4);
		// priority among pending requests
		ack_on <= 1'b0;
		wr(OFF_FLAGS, 32'h0);
		wr(OFF_CTRL, 32'h73);
		fire(10'h061);
		rc(OFF_STATUS, 32'h8);
		chk(32'(vec), 32'(VEC_LOW_SUPPLY));
		ack_on <= 1'b1;
		repeat (40) @(posedge aclk);
		rc(OFF_FLAGS, 32'h0001_0001);
		chk(32'(n_push), 32'd7);
		// full stack holds the request back
		full_on <= 1'b1;
		wr(OFF_FLAGS, 32'h0);
		fire(10'h001);
		// vector keeps the timer group last presented
		rc(OFF_STATUS, 32'h3);
		full_on <= 1'b0;
		repeat (20) @(posedge aclk);
		chk(32'(n_push), 32'd8);
		// interval from system clock over four
		wr(OFF_CTRL, 32'h0);
		wr(OFF_FLAGS, 32'h0);
		wr(OFF_TIME_BASE, 32'hc0);
		repeat (16300) @(posedge aclk);
		rc(OFF_FLAGS, 32'h0);
		repeat (150) @(posedge aclk);
		rc(OFF_FLAGS, 32'h40);
		// interval from dedicated clock, serviced
		wr(OFF_TIME_BASE, 32'h0);
		wr(OFF_FLAGS, 32'h0);
		wr(OFF_CTRL, 32'h05);
		wr(OFF_TIME_BASE, 32'h90);
		tick(8191);
		repeat (10) @(posedge aclk);
		chk(32'(n_push), 32'd8);
		tick(1);
		repeat (20) @(posedge aclk);
		chk(32'(n_push), 32'd9);
		rc(OFF_FLAGS, 32'h0);
		// wake from sleep
		wr(OFF_CTRL, 32'h0);
		wr(OFF_TIME_BASE, 32'h0);
		wr(OFF_FLAGS, 32'h2);
		sleep <= 1'b1;
		repeat (4) @(posedge aclk);
		i = n_wake;
		fire(10'h002);
		chk(32'(n_wake), 32'(i));
		fire(10'h004);
		chk(32'(n_wake), 32'(i + 1));
		summarize();
	end
endmodule : peripheral_interrupt_and_time_base_tb
`default_nettype wire
